//--- core/liel_event_low.sv
// Purpose: low eighteen event bits of a link interrupt event register
// Assumes: the ten single-bit event inputs are one-cycle pulses on aclk; the iso context bits are levels
// Notes:   AXI4-Lite slave; sticky bits, mask, one level interrupt
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`include "liel_map.svh"
`timescale 1ns/1ps
`default_nettype none

module liel_event_low
    import liel_pkg::*;
#(
    parameter int NUM_ISO_RX = 4,
    parameter int NUM_ISO_TX = 4
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [`LIEL_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`LIEL_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    bus_reset_seen_ev,
    input  wire logic                    node_scan_done_ev,
    input  wire logic                    atomic_reply_unacked_ev,
    input  wire logic                    buffered_write_host_fault_ev,
    input  wire logic                    reply_packet_stored_ev,
    input  wire logic                    request_packet_stored_ev,
    input  wire logic                    async_reply_receive_dma_ev,
    input  wire logic                    async_request_receive_dma_ev,
    input  wire logic                    reply_send_done_ev,
    input  wire logic                    request_send_done_ev,
    input  wire logic [NUM_ISO_RX-1:0]   iso_rx_event,
    input  wire logic [NUM_ISO_RX-1:0]   iso_rx_mask,
    input  wire logic [NUM_ISO_TX-1:0]   iso_tx_event,
    input  wire logic [NUM_ISO_TX-1:0]   iso_tx_mask,
    output logic                         irq
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (NUM_ISO_RX < 1 || NUM_ISO_RX > 32) begin : g_bad_rx
        $error("NUM_ISO_RX must lie in 1..32");
    end
    if (NUM_ISO_TX < 1 || NUM_ISO_TX > 32) begin : g_bad_tx
        $error("NUM_ISO_TX must lie in 1..32");
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : strb_mask

    function automatic logic is_mapped(input logic [`LIEL_ADDR_W-1:0] a);
        return (a == `LIEL_OFS_EVENT_SET) || (a == `LIEL_OFS_EVENT_CLR)
            || (a == `LIEL_OFS_MASK_SET) || (a == `LIEL_OFS_MASK_CLR)
            || (a == `LIEL_OFS_PENDING);
    endfunction : is_mapped

    // the event word as software sees it, summaries merged in
    function automatic logic [31:0] event_view(input liel_state_s st);
        logic [31:0] v;
        v = st.event_reg & `LIEL_LATCHED_MASK;
        v[`LIEL_BIT_RX_SUMMARY] = st.rx_sum;
        v[`LIEL_BIT_TX_SUMMARY] = st.tx_sum;
        return v;
    endfunction : event_view

    function automatic logic [31:0] read_word(
        input logic [`LIEL_ADDR_W-1:0] a,
        input liel_state_s             st
    );
        logic [31:0] v;
        v = '0;
        case (a)
            `LIEL_OFS_EVENT_SET,
            `LIEL_OFS_EVENT_CLR: begin
                v = event_view(st);
            end
            `LIEL_OFS_MASK_SET,
            `LIEL_OFS_MASK_CLR: begin
                v = st.mask_reg;
            end
            `LIEL_OFS_PENDING: begin
                v = event_view(st) & st.mask_reg;
            end
            default: begin
                v = '0;
            end
        endcase
        return v;
    endfunction : read_word

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    liel_state_s state_reg;
    liel_state_s state_next;

    logic [31:0] hw_set;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic [31:0] wr_bits;
    logic        do_write;
    logic [31:0] ev;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        hw_set     = '0;
        sw_set     = '0;
        sw_clr     = '0;
        ev         = state_reg.event_reg;

        // live summaries, one register stage behind the context bits
        state_next.rx_sum = |(iso_rx_event & iso_rx_mask);
        state_next.tx_sum = |(iso_tx_event & iso_tx_mask);

        // write address and data are taken independently
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end

        do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
        wr_bits  = state_reg.w_data & strb_mask(state_reg.w_strb);

        if (do_write) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = is_mapped(state_reg.aw_addr)
                               ? `LIEL_RESP_OKAY : `LIEL_RESP_SLVERR;
            case (state_reg.aw_addr)
                `LIEL_OFS_EVENT_SET: begin
                    sw_set = wr_bits & `LIEL_LATCHED_MASK;
                end
                `LIEL_OFS_EVENT_CLR: begin
                    sw_clr = wr_bits & `LIEL_LATCHED_MASK;
                end
                `LIEL_OFS_MASK_SET: begin
                    state_next.mask_reg = state_reg.mask_reg
                                        | (wr_bits & `LIEL_IMPL_MASK);
                end
                `LIEL_OFS_MASK_CLR: begin
                    state_next.mask_reg = state_reg.mask_reg
                                        & ~(wr_bits & `LIEL_IMPL_MASK);
                end
                default: begin
                    sw_set = '0;
                end
            endcase
        end

        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // one write in flight: no new address or data until answered
        state_next.awready = !state_next.aw_held && !state_next.bvalid;
        state_next.wready  = !state_next.w_held && !state_next.bvalid;

        // hardware events
        hw_set[`LIEL_BIT_BUS_RESET]   = bus_reset_seen_ev;
        hw_set[`LIEL_BIT_SCAN_DONE]   = node_scan_done_ev;
        hw_set[`LIEL_BIT_SCAN_STICKY] = node_scan_done_ev;
        hw_set[`LIEL_BIT_ATOMIC_ERR]  = atomic_reply_unacked_ev;
        hw_set[`LIEL_BIT_BUFWR_ERR]   = buffered_write_host_fault_ev;
        hw_set[`LIEL_BIT_RPLY_PKT]    = reply_packet_stored_ev;
        hw_set[`LIEL_BIT_RQST_PKT]    = request_packet_stored_ev;
        hw_set[`LIEL_BIT_RPLY_RXDMA]  = async_reply_receive_dma_ev;
        hw_set[`LIEL_BIT_RQST_RXDMA]  = async_request_receive_dma_ev;
        hw_set[`LIEL_BIT_RPLY_SEND]   = reply_send_done_ev;
        hw_set[`LIEL_BIT_RQST_SEND]   = request_send_done_ev;

        // software first, then hardware so a hardware set always wins a clear
        ev = (ev | sw_set) & ~sw_clr;
        if (bus_reset_seen_ev) begin
            ev[`LIEL_BIT_SCAN_DONE] = 1'b0;
        end
        ev = ev | hw_set;
        // reserved and summary positions never hold state
        state_next.event_reg = ev & `LIEL_LATCHED_MASK;

        // read channel
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state_reg.arready) begin
            state_next.rvalid = 1'b1;
            state_next.rdata  = read_word(s_axi_araddr, state_reg);
            state_next.rresp  = is_mapped(s_axi_araddr)
                              ? `LIEL_RESP_OKAY : `LIEL_RESP_SLVERR;
        end
        state_next.arready = !state_next.rvalid;

        // level interrupt while any unmasked bit stands
        state_next.irq = |(event_view(state_next) & state_next.mask_reg);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg           <= '0;
            state_reg.event_reg <= `LIEL_EVENT_RST;
            state_reg.mask_reg  <= `LIEL_MASK_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready  = state_reg.wready;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rdata   = state_reg.rdata;
    assign s_axi_rresp   = state_reg.rresp;
    assign irq           = state_reg.irq;

endmodule : liel_event_low

`default_nettype wire

//--- core/liel_map.svh
// Purpose: offsets, bit positions and reset values of the low event bits
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes:   definitions only
`ifndef LIEL_MAP_SVH
`define LIEL_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LIEL_ADDR_W          8
`define LIEL_OFS_EVENT_SET   8'h00
`define LIEL_OFS_EVENT_CLR   8'h04
`define LIEL_OFS_MASK_SET    8'h08
`define LIEL_OFS_MASK_CLR    8'h0C
`define LIEL_OFS_PENDING     8'h10

// ----------------------------------------------------------------------
// event bit positions
// ----------------------------------------------------------------------
`define LIEL_BIT_BUS_RESET   17
`define LIEL_BIT_SCAN_DONE   16
`define LIEL_BIT_SCAN_STICKY 15
`define LIEL_BIT_ATOMIC_ERR  9
`define LIEL_BIT_BUFWR_ERR   8
`define LIEL_BIT_RX_SUMMARY  7
`define LIEL_BIT_TX_SUMMARY  6
`define LIEL_BIT_RPLY_PKT    5
`define LIEL_BIT_RQST_PKT    4
`define LIEL_BIT_RPLY_RXDMA  3
`define LIEL_BIT_RQST_RXDMA  2
`define LIEL_BIT_RPLY_SEND   1
`define LIEL_BIT_RQST_SEND   0

// ----------------------------------------------------------------------
// field masks and reset values
// ----------------------------------------------------------------------
`define LIEL_LATCHED_MASK    32'h0003_833F
`define LIEL_IMPL_MASK       32'h0003_83FF
`define LIEL_EVENT_RST       32'h0000_0000
`define LIEL_MASK_RST        32'h0000_0000
`define LIEL_RESP_OKAY       2'h0
`define LIEL_RESP_SLVERR     2'h2

`endif

//--- core/liel_pkg.sv
// Purpose: types of the low event bits block
// Assumes: liel_map.svh gives the widths
// Notes:   whole module state is one packed struct
`include "liel_map.svh"

package liel_pkg;

    // ------------------------------------------------------------------
    // module state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]               event_reg;
        logic [31:0]               mask_reg;
        logic                      rx_sum;
        logic                      tx_sum;
        logic                      aw_held;
        logic [`LIEL_ADDR_W-1:0]   aw_addr;
        logic                      w_held;
        logic [31:0]               w_data;
        logic [3:0]                w_strb;
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
        logic                      irq;
    } liel_state_s;

endpackage : liel_pkg

//--- sim/liel_event_low_monitor.sv
// Purpose: assertions on the low event bits at the block ports
// Assumes: reads of 0x00/0x04 return the event view, one edge after taking
// Notes:   bound to every liel_event_low instance
`include "liel_map.svh"
`timescale 1ns/1ps
`default_nettype none

module liel_event_low_monitor #(
    parameter int NUM_ISO_RX = 4,
    parameter int NUM_ISO_TX = 4
) (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic [`LIEL_ADDR_W-1:0] s_axi_araddr,
    input wire logic                    s_axi_rvalid,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic                    bus_reset_seen_ev,
    input wire logic                    node_scan_done_ev,
    input wire logic                    atomic_reply_unacked_ev,
    input wire logic                    buffered_write_host_fault_ev,
    input wire logic                    request_send_done_ev,
    input wire logic [NUM_ISO_RX-1:0]   iso_rx_event,
    input wire logic [NUM_ISO_RX-1:0]   iso_rx_mask,
    input wire logic [NUM_ISO_TX-1:0]   iso_tx_event,
    input wire logic [NUM_ISO_TX-1:0]   iso_tx_mask
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // $past only takes a plain signal, so the summaries get their own nets
    wire logic rx_any = |(iso_rx_event & iso_rx_mask);
    wire logic tx_any = |(iso_tx_event & iso_tx_mask);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // first beat of a read of the event view; state was sampled one edge earlier
    sequence s_ev_rd;
        $rose(s_axi_rvalid) && ($past(s_axi_araddr) inside {8'h00, 8'h04});
    endsequence

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_bus_reset;
        s_ev_rd ##0 ($past(bus_reset_seen_ev, 2) && !$past(node_scan_done_ev, 2))
            |-> s_axi_rdata[17] && !s_axi_rdata[16];
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("bus reset bits wrong");

    property p_scan_done;
        s_ev_rd ##0 $past(node_scan_done_ev, 2) |-> s_axi_rdata[16] && s_axi_rdata[15];
    endproperty
    a_scan_done: assert property (p_scan_done) else $error("scan done bits wrong");

    property p_reserved;
        $rose(s_axi_rvalid) |-> s_axi_rdata[14:10] == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_atomic;
        s_ev_rd ##0 $past(atomic_reply_unacked_ev, 2) |-> s_axi_rdata[9];
    endproperty
    a_atomic: assert property (p_atomic) else $error("bit 9 not set");

    property p_bufwr;
        s_ev_rd ##0 $past(buffered_write_host_fault_ev, 2) |-> s_axi_rdata[8];
    endproperty
    a_bufwr: assert property (p_bufwr) else $error("bit 8 not set");

    property p_rx_sum;
        s_ev_rd |-> s_axi_rdata[7] == $past(rx_any, 2);
    endproperty
    a_rx_sum: assert property (p_rx_sum) else $error("receive summary wrong");

    property p_tx_sum;
        s_ev_rd |-> s_axi_rdata[6] == $past(tx_any, 2);
    endproperty
    a_tx_sum: assert property (p_tx_sum) else $error("transmit summary wrong");

    property p_req_send;
        s_ev_rd ##0 $past(request_send_done_ev, 2) |-> s_axi_rdata[0];
    endproperty
    a_req_send: assert property (p_req_send) else $error("bit 0 not set");
endmodule : liel_event_low_monitor

bind liel_event_low liel_event_low_monitor #(
    .NUM_ISO_RX(NUM_ISO_RX),
    .NUM_ISO_TX(NUM_ISO_TX)
) i_mon (.*);

`default_nettype wire

//--- sim/liel_event_low_tb.sv
// Purpose: self-checking bench of the low event bits block
// Assumes: AXI4-Lite master tasks, model of the event and mask words
// Notes:   seeded random events, masks and clears among fixed corners
`include "liel_map.svh"
`timescale 1ns/1ps
`default_nettype none

module liel_event_low_tb;
    logic [`LIEL_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, e_m, m_m, d, v;
    logic [3:0]  s_axi_wstrb, iso_rx_event, iso_rx_mask, iso_tx_event, iso_tx_mask;
    logic [9:0]  ev_v;
    logic [1:0]  r;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic   irq;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic   bus_reset_seen_ev, node_scan_done_ev, atomic_reply_unacked_ev;
    wire logic   buffered_write_host_fault_ev, reply_packet_stored_ev;
    wire logic   request_packet_stored_ev, async_reply_receive_dma_ev;
    wire logic   async_request_receive_dma_ev, reply_send_done_ev, request_send_done_ev;
    int          fail_count, n_compared, seed, i;

    assign {bus_reset_seen_ev, node_scan_done_ev, atomic_reply_unacked_ev,
            buffered_write_host_fault_ev, reply_packet_stored_ev, request_packet_stored_ev,
            async_reply_receive_dma_ev, async_request_receive_dma_ev, reply_send_done_ev,
            request_send_done_ev} = ev_v;

    liel_event_low #(.NUM_ISO_RX(4), .NUM_ISO_TX(4)) i_dut (.*);

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // live summaries are not latched, so they come from the inputs now
    function automatic logic [31:0] view_f(input logic [31:0] e);
        view_f = (e & 32'h0003_833F) | {24'h000000, |(iso_rx_event & iso_rx_mask),
                 |(iso_tx_event & iso_tx_mask), 6'h00};
    endfunction : view_f

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] st,
                          input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= dd;
        s_axi_wstrb   <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            finish_test();
        end
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : axi_wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            finish_test();
        end
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd_chk

    // one-cycle event pulses, folded into the model as the device must
    task automatic pulse(input logic [9:0] pv);
        @(posedge aclk);
        ev_v <= pv;
        @(posedge aclk);
        ev_v <= 10'h000;
        e_m = e_m | {22'h0, pv[7:6], 2'h0, pv[5:0]};
        if (pv[9]) e_m = (e_m | 32'h0002_0000) & ~32'h0001_0000;
        if (pv[8]) e_m = e_m | 32'h0001_8000;
    endtask : pulse

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_wdata, s_axi_wstrb, ev_v, iso_rx_event, iso_rx_mask} = '0;
        {iso_tx_event, iso_tx_mask, fail_count, n_compared, e_m, m_m} = '0;
        seed = 32'h9808;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(8'h00, 32'h0, 2'h0);
        rd_chk(8'h08, 32'h0, 2'h0);
        rd_chk(8'h14, 32'h0, 2'h2);
        axi_wr(8'h14, 32'hFFFF_FFFF, 4'hF, 2'h2);
        for (i = 0; i < 10; i++) begin
            pulse(10'h001 << i);
            rd_chk(8'h00, view_f(e_m), 2'h0);
        end
        pulse(10'h200);
        rd_chk(8'h04, view_f(e_m), 2'h0);
        pulse(10'h300);
        rd_chk(8'h00, view_f(e_m), 2'h0);
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            {iso_rx_event, iso_rx_mask, iso_tx_event, iso_tx_mask} <= 16'($random(seed));
            pulse(10'($random(seed) & $random(seed)));
            v = $random(seed);
            axi_wr(8'h0C, 32'hFFFF_FFFF, 4'hF, 2'h0);
            axi_wr(8'h08, v, 4'hF, 2'h0);
            m_m = v & 32'h0003_83FF;
            rd_chk(8'h08, m_m, 2'h0);
            rd_chk(8'h00, view_f(e_m), 2'h0);
            rd_chk(8'h10, view_f(e_m) & m_m, 2'h0);
            chk({31'h0, irq}, {31'h0, |(view_f(e_m) & m_m)});
            d = $random(seed);
            v = $random(seed);
            axi_wr(8'h04, d, v[3:0], 2'h0);
            e_m = e_m & ~(d & {{8{v[3]}}, {8{v[2]}}, {8{v[1]}}, {8{v[0]}}});
            rd_chk(8'h04, view_f(e_m), 2'h0);
            d = $random(seed);
            axi_wr(8'h00, d, 4'hF, 2'h0);
            e_m = e_m | (d & 32'h0003_833F);
            axi_wr(8'h10, 32'hFFFF_FFFF, 4'hF, 2'h0);
            rd_chk(8'h00, view_f(e_m), 2'h0);
        end
        finish_test();
    end
endmodule : liel_event_low_tb

`default_nettype wire
